/* File: design/bil_loader.sv */
// Boot image loader: fetches the header-bearing first-stage image into internal SRAM,
// checks its byte sum, falls back to SD channel 2, then serves device-to-memory copies.
// Assumes the media controller and the memory write port sit on core_clk.
`include "bil_defs.svh"
module bil_loader #(
  parameter int unsigned SEC_PLL_HZ = 80000000
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    boot_start,
  input  wire bil_pkg::bil_dev_t       boot_dev,
  input  wire bil_pkg::bil_ecc_t       boot_ecc,
  input  wire logic [4:0]              boot_bus_width,
  input  wire bil_pkg::bil_nand_geom_t nand_geom,
  input  wire bil_pkg::bil_media_rsp_t media_rsp,
  input  wire bil_pkg::bil_svc_req_t   svc_req,
  output bil_pkg::bil_media_cmd_t      media_cmd,
  output bil_pkg::bil_mem_wr_t         mem_wr,
  output logic                         boot_done,
  output logic                         boot_ok,
  output logic                         boot_fallback,
  output logic [31:0]                  exec_addr,
  output logic                         svc_busy,
  output logic                         svc_done,
  output logic                         svc_ok
);
  import bil_pkg::*;

  localparam int unsigned SD_DIV = SEC_PLL_HZ / `BIL_SD_CLK_HZ;

  initial begin
    if (SD_DIV < 1 || SD_DIV > 255 || SD_DIV * `BIL_SD_CLK_HZ != SEC_PLL_HZ) begin
      $error("SEC_PLL_HZ must be a whole multiple of the card clock, 1 to 255 times");
    end
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPEN, ST_HDR, ST_DATA, ST_CHECK, ST_RETRY, ST_DONE, ST_SVC_OPEN, ST_SVC
  } bil_state_t;

  bil_state_t     state_ff;
  bil_media_cmd_t cmd_ff;
  bil_mem_wr_t    wr_ff;
  bil_svc_req_t   svc_ff;
  logic [31:0]    cnt_ff;
  logic [31:0]    len_ff;
  logic [31:0]    csum_ff;
  logic [31:0]    svc_total_ff;
  logic [31:0]    exec_ff;
  logic           fallback_ff;
  logic           done_ff;
  logic           ok_ff;
  logic           svc_done_ff;
  logic           svc_ok_ff;
  logic           svc_busy_ff;
  logic [31:0]    sum;

  function automatic logic [31:0] first_unit(input bil_dev_t dev);
    case (dev)
      BIL_DEV_SD, BIL_DEV_SSD: first_unit = `BIL_SDSSD_FIRST_BLK;
      BIL_DEV_EMMC:            first_unit = `BIL_EMMC_FIRST_BLK;
      default:                 first_unit = `BIL_NAND_FIRST_PAGE;
    endcase
  endfunction : first_unit

  function automatic logic [4:0] ecc_parity(input bil_ecc_t ecc);
    case (ecc)
      BIL_ECC8:  ecc_parity = `BIL_ECC8_PARITY;
      BIL_ECC16: ecc_parity = `BIL_ECC16_PARITY;
      default:   ecc_parity = 5'h00;
    endcase
  endfunction : ecc_parity

  // Fills in the fields every media request shares; the caller sets what differs.
  function automatic bil_media_cmd_t make_cmd(input bil_dev_t dev, input logic [1:0] chan,
                                              input logic [4:0] width, input logic [31:0] unit,
                                              input bil_ecc_t ecc, input logic udma);
    bil_media_cmd_t c;
    c               = '0;
    c.en            = 1'b1;
    c.dev           = dev;
    c.chan          = chan;
    c.bus_width     = width;
    c.start_unit    = unit;
    c.ecc           = ecc;
    c.ecc_parity    = ecc_parity(ecc);
    c.ecc_ofs       = `BIL_SPARE_OS_BYTES;
    c.udma          = udma;
    c.clk_secondary = (dev == BIL_DEV_SD) || (dev == BIL_DEV_EMMC);
    c.clk_div       = 8'(SD_DIV);
    make_cmd        = c;
  endfunction : make_cmd

  // Geometry that each NAND page service will accept.
  function automatic logic svc_geom_ok(input bil_svc_kind_t kind, input bil_nand_geom_t g);
    case (kind)
      BIL_SVC_NAND8:
        svc_geom_ok = !g.bus16 && (g.page_bytes == `BIL_PAGE_2K || g.page_bytes == `BIL_PAGE_4K);
      BIL_SVC_NAND4:
        svc_geom_ok = g.bus16 && g.page_bytes == `BIL_PAGE_2K && g.addr_cycles == `BIL_ADDR_CYC_5;
      BIL_SVC_NAND8_128P:
        svc_geom_ok = !g.bus16 && g.page_bytes == `BIL_PAGE_2K && g.pages_per_block == `BIL_PPB_128;
      default:
        svc_geom_ok = 1'b1;
    endcase
  endfunction : svc_geom_ok

  function automatic logic [31:0] svc_bytes(input bil_svc_req_t r, input bil_nand_geom_t g);
    case (r.kind)
      BIL_SVC_NAND8, BIL_SVC_NAND4, BIL_SVC_NAND8_128P: svc_bytes = {19'h0_0000, g.page_bytes};
      BIL_SVC_HYBRID: svc_bytes = 32'(r.count) * 32'(g.page_bytes);
      default:        svc_bytes = {7'h00, r.count, 9'h000}; // blocks of 512 bytes
    endcase
  endfunction : svc_bytes

  logic byte_in;
  logic hdr_last;
  logic len_bad;
  logic data_last;
  logic load_err;
  logic sum_match;
  logic attempt_fail;
  logic svc_last;
  logic svc_abort;
  logic svc_refuse;

  assign byte_in      = media_rsp.valid && cmd_ff.en;
  assign hdr_last     = state_ff == ST_HDR && byte_in && !media_rsp.err && cnt_ff == `BIL_HDR_BYTES - 32'h1;
  assign len_bad      = len_ff == 32'h0 || len_ff > `BIL_IMG_MAX;
  assign data_last    = state_ff == ST_DATA && byte_in && !media_rsp.err && cnt_ff + 32'h1 == len_ff;
  assign load_err     = (state_ff == ST_HDR || state_ff == ST_DATA) && media_rsp.valid && media_rsp.err;
  assign sum_match    = sum == csum_ff;
  assign attempt_fail = load_err || (hdr_last && len_bad) || (state_ff == ST_CHECK && !sum_match);
  assign svc_last     = state_ff == ST_SVC && byte_in && !media_rsp.err && cnt_ff + 32'h1 == svc_total_ff;
  assign svc_abort    = state_ff == ST_SVC && media_rsp.valid && media_rsp.err;
  // Requests before the boot load has finished are answered at once with a failure.
  assign svc_refuse   = svc_req.valid && !done_ff;

  bil_sum_acc u_sum (
    .core_clk (core_clk),
    .rst      (rst),
    .clr      (state_ff == ST_OPEN),
    .add      (state_ff == ST_DATA && byte_in && !media_rsp.err),
    .data     (media_rsp.data),
    .sum_ff   (sum)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE:     if (boot_start) state_ff <= ST_OPEN;
        ST_OPEN:     state_ff <= ST_HDR;
        ST_HDR: begin
          if (attempt_fail) begin
            state_ff <= fallback_ff ? ST_DONE : ST_RETRY;
          end else if (hdr_last) begin
            state_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (attempt_fail) begin
            state_ff <= fallback_ff ? ST_DONE : ST_RETRY;
          end else if (data_last) begin
            state_ff <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (sum_match) begin
            state_ff <= ST_DONE;
          end else begin
            state_ff <= fallback_ff ? ST_DONE : ST_RETRY;
          end
        end
        ST_RETRY:    state_ff <= ST_OPEN;
        ST_DONE:     if (svc_req.valid) state_ff <= ST_SVC_OPEN;
        ST_SVC_OPEN: state_ff <= svc_geom_ok(svc_ff.kind, nand_geom) ? ST_SVC : ST_DONE;
        ST_SVC:      if (svc_last || svc_abort) state_ff <= ST_DONE;
        default:     state_ff <= ST_IDLE;
      endcase
    end
  end

  // One counter serves header, image and service bytes; it restarts at each phase.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h0;
    end else if (state_ff == ST_OPEN || hdr_last || state_ff == ST_SVC_OPEN) begin
      cnt_ff <= 32'h0;
    end else if (byte_in && !media_rsp.err) begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  // Header fields are caught little-endian as they stream past; they are the same bytes
  // that land at the header addresses in SRAM, so no read-back is needed.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      len_ff  <= 32'h0;
      csum_ff <= 32'h0;
    end else if (state_ff == ST_HDR && byte_in && !media_rsp.err) begin
      if (cnt_ff[3:2] == `BIL_HDR_LEN_OFS) begin
        len_ff[cnt_ff[1:0]*8 +: 8] <= media_rsp.data;
      end
      if (cnt_ff[3:2] == `BIL_HDR_CSUM_OFS) begin
        csum_ff[cnt_ff[1:0]*8 +: 8] <= media_rsp.data;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fallback_ff <= 1'b0;
    end else if (state_ff == ST_RETRY) begin
      fallback_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_ff <= '0;
    end else begin
      case (state_ff)
        ST_OPEN: begin
          if (fallback_ff) begin
            cmd_ff <= make_cmd(BIL_DEV_SD, `BIL_FALLBACK_CH, `BIL_FALLBACK_WIDTH,
                               first_unit(BIL_DEV_SD), BIL_ECC_NONE, 1'b0);
          end else begin
            cmd_ff <= make_cmd(boot_dev, 2'h0, boot_bus_width, first_unit(boot_dev),
                               boot_dev == BIL_DEV_NAND ? boot_ecc : BIL_ECC_NONE, 1'b0);
          end
        end
        ST_HDR, ST_DATA: begin
          if (attempt_fail || data_last) begin
            cmd_ff.en <= 1'b0; // Stops the stream on a failure, or else after exactly the header plus len bytes.
          end
        end
        ST_SVC_OPEN: begin
          if (svc_geom_ok(svc_ff.kind, nand_geom)) begin
            case (svc_ff.kind)
              BIL_SVC_NAND8, BIL_SVC_NAND8_128P:
                cmd_ff <= make_cmd(BIL_DEV_NAND, 2'h0, 5'h08,
                                   32'(svc_ff.block * nand_geom.pages_per_block) + {16'h0, svc_ff.page},
                                   BIL_ECC8, 1'b0);
              BIL_SVC_NAND4:
                cmd_ff <= make_cmd(BIL_DEV_NAND, 2'h0, 5'h10,
                                   32'(svc_ff.block * nand_geom.pages_per_block) + {16'h0, svc_ff.page},
                                   BIL_ECC4, 1'b0);
              BIL_SVC_HYBRID:
                cmd_ff <= make_cmd(BIL_DEV_HYBRID, 2'h0, 5'h10,
                                   32'(svc_ff.block * nand_geom.pages_per_block) + {16'h0, svc_ff.page},
                                   BIL_ECC_NONE, 1'b0);
              BIL_SVC_SD:
                cmd_ff <= make_cmd(BIL_DEV_SD, 2'h0, 5'h04, svc_ff.block, BIL_ECC_NONE, 1'b0);
              BIL_SVC_EMMC:
                cmd_ff <= make_cmd(BIL_DEV_EMMC, 2'h0, svc_ff.bus_width, svc_ff.block,
                                   BIL_ECC_NONE, 1'b0);
              default:
                cmd_ff <= make_cmd(BIL_DEV_SSD, 2'h0, 5'h10, svc_ff.block, BIL_ECC_NONE,
                                   svc_ff.kind == BIL_SVC_SSD_UDMA);
            endcase
          end
        end
        ST_SVC: begin
          if (svc_last || svc_abort) begin
            cmd_ff.en <= 1'b0;
          end
        end
        default: cmd_ff.en <= 1'b0;
      endcase
    end
  end

  // Memory write port: header and image go to SRAM from its base, copies go to the caller's buffer.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ff <= '0;
    end else begin
      wr_ff.valid <= 1'b0;
      wr_ff.data  <= media_rsp.data;
      if (byte_in && !media_rsp.err) begin
        case (state_ff)
          ST_HDR: begin
            wr_ff.valid <= 1'b1;
            wr_ff.addr  <= `BIL_SRAM_BASE + cnt_ff;
          end
          ST_DATA: begin
            wr_ff.valid <= 1'b1;
            wr_ff.addr  <= `BIL_EXEC_ADDR + cnt_ff;
          end
          ST_SVC: begin
            wr_ff.valid <= 1'b1;
            wr_ff.addr  <= svc_ff.dest + cnt_ff;
          end
          default: wr_ff.valid <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      ok_ff   <= 1'b0;
      exec_ff <= 32'h0;
    end else if (state_ff == ST_CHECK && sum_match) begin
      done_ff <= 1'b1;
      ok_ff   <= 1'b1;
      exec_ff <= `BIL_EXEC_ADDR;
    end else if (attempt_fail && fallback_ff) begin
      done_ff <= 1'b1;
      ok_ff   <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      svc_ff       <= '0;
      svc_total_ff <= 32'h0;
    end else if (state_ff == ST_DONE && svc_req.valid) begin
      svc_ff       <= svc_req;
      svc_total_ff <= svc_bytes(svc_req, nand_geom);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      svc_done_ff <= 1'b0;
      svc_ok_ff   <= 1'b0;
    end else begin
      svc_done_ff <= 1'b0;
      if (svc_refuse) begin
        svc_done_ff <= 1'b1;
        svc_ok_ff   <= 1'b0;
      end else if (state_ff == ST_SVC_OPEN && !svc_geom_ok(svc_ff.kind, nand_geom)) begin
        svc_done_ff <= 1'b1;
        svc_ok_ff   <= 1'b0;
      end else if (svc_last || svc_abort) begin
        svc_done_ff <= 1'b1;
        svc_ok_ff   <= svc_last;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      svc_busy_ff <= 1'b0;
    end else begin
      svc_busy_ff <= (state_ff == ST_DONE && svc_req.valid) || (state_ff == ST_SVC && !svc_last && !svc_abort)
                     || (state_ff == ST_SVC_OPEN && svc_geom_ok(svc_ff.kind, nand_geom));
    end
  end

  assign media_cmd     = cmd_ff;
  assign mem_wr        = wr_ff;
  assign boot_done     = done_ff;
  assign boot_ok       = ok_ff;
  assign boot_fallback = fallback_ff;
  assign exec_addr     = exec_ff;
  assign svc_busy      = svc_busy_ff;
  assign svc_done      = svc_done_ff;
  assign svc_ok        = svc_ok_ff;
endmodule : bil_loader

/* File: design/bil_sum_acc.sv */
// Unsigned 32-bit byte-sum accumulator for image checking.
// Assumes clear and add come from logic on core_clk.
module bil_sum_acc (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic        add,
  input  wire logic [7:0]  data,
  output logic      [31:0] sum_ff
);
  // Clear wins over add: a new attempt never inherits a stale byte.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sum_ff <= 32'h0000_0000;
    end else if (clr) begin
      sum_ff <= 32'h0000_0000;
    end else if (add) begin
      sum_ff <= sum_ff + {24'h00_0000, data};
    end
  end
endmodule : bil_sum_acc

/* File: shared/bil_defs.svh */
// Constants of the boot image loader: placement, header layout, spare layout, limits and clocks.
// Assumes the includer wants plain `define values; types live in bil_pkg.
//
// Contract
// - SD/MMC and SSD keep block zero reserved; image read starts at block one.
// - eMMC image starts at block zero and is read from there.
// - Raw NAND and hybrid flash image starts at page zero.
// - NAND spare area: first 12 bytes for OS, ECC parity from the 13th byte.
// - 8-bit ECC mode expects 13 parity bytes per page.
// - 16-bit ECC mode expects 26 parity bytes per page.
// - Length is read from the header first, then exactly that many bytes are copied.
// - After the copy the copied bytes are summed and compared with the header checksum.
// - Match hands over execution; mismatch retries on SD channel 2, 4-bit bus.
// - Checksum adds each byte into an unsigned 32-bit sum; length counts bytes.
// - SD/MMC and eMMC copies run the card at 20 MHz from the secondary PLL.
// - 8-bit ECC page read accepts only 8-bit bus NAND with 2048 or 4096 byte pages.
// - 4-bit ECC page read accepts only 16-bit bus, 2048 byte page, five address cycles.
// - A separate 8-bit ECC page read serves 128 pages per block, 2K pages.
// - SSD copy offers PIO and UDMA, each with start block, count and destination.
// - eMMC copy uses the bus width that the caller selects.
// - First-stage image is at most 16 KB.
// - Header-bearing image executes at 0xd0020010, just past its header.
// - Header checksum is taken from the loaded copy at 0xd0020008.
// - Headerless images sit at 0xd0020000 with no header check; the loader treats every image as header-bearing and checks its header.
`ifndef BIL_DEFS_SVH
`define BIL_DEFS_SVH
`define BIL_BLOCK_SHIFT      9
`define BIL_SDSSD_FIRST_BLK  32'h0000_0001
`define BIL_EMMC_FIRST_BLK   32'h0000_0000
`define BIL_NAND_FIRST_PAGE  32'h0000_0000
`define BIL_SPARE_OS_BYTES   6'h0c
`define BIL_SPARE_SMALL      8'h40
`define BIL_ECC8_PARITY      5'h0d
`define BIL_ECC16_PARITY     5'h1a
`define BIL_IMG_MAX          32'h0000_4000
`define BIL_HDR_BYTES        32'h0000_0010
`define BIL_HDR_LEN_OFS      2'h0
`define BIL_HDR_CSUM_OFS     2'h2
`define BIL_SRAM_BASE        32'hd002_0000
`define BIL_HDR_CSUM_ADDR    32'hd002_0008
`define BIL_EXEC_ADDR        32'hd002_0010
`define BIL_FALLBACK_CH      2'h2
`define BIL_FALLBACK_WIDTH   5'h04
`define BIL_SD_CLK_HZ        20000000
`define BIL_PAGE_2K          13'h0800
`define BIL_PAGE_4K          13'h1000
`define BIL_PPB_128          9'h080
`define BIL_ADDR_CYC_5       3'h5
`endif

/* File: shared/bil_pkg.sv */
// Types shared by the boot image loader modules.
// Assumes bil_defs.svh supplies the numeric constants.
package bil_pkg;
  typedef enum logic [2:0] {BIL_DEV_SD, BIL_DEV_EMMC, BIL_DEV_SSD, BIL_DEV_NAND, BIL_DEV_HYBRID} bil_dev_t;
  typedef enum logic [1:0] {BIL_ECC_NONE, BIL_ECC4, BIL_ECC8, BIL_ECC16} bil_ecc_t;
  typedef enum logic [2:0] {
    BIL_SVC_NAND8, BIL_SVC_NAND4, BIL_SVC_NAND8_128P, BIL_SVC_SD,
    BIL_SVC_EMMC, BIL_SVC_HYBRID, BIL_SVC_SSD_PIO, BIL_SVC_SSD_UDMA
  } bil_svc_kind_t;

  typedef struct packed {
    logic        en;
    bil_dev_t    dev;
    logic [1:0]  chan;
    logic [4:0]  bus_width;
    logic [31:0] start_unit;
    bil_ecc_t    ecc;
    logic [4:0]  ecc_parity;
    logic [5:0]  ecc_ofs;
    logic        udma;
    logic        clk_secondary;
    logic [7:0]  clk_div;
  } bil_media_cmd_t;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } bil_media_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [7:0]  data;
  } bil_mem_wr_t;

  typedef struct packed {
    logic [12:0] page_bytes;
    logic        bus16;
    logic [2:0]  addr_cycles;
    logic [8:0]  pages_per_block;
  } bil_nand_geom_t;

  typedef struct packed {
    logic          valid;
    bil_svc_kind_t kind;
    logic [31:0]   block;
    logic [15:0]   page;
    logic [15:0]   count;
    logic [31:0]   dest;
    logic [4:0]    bus_width;
  } bil_svc_req_t;
endpackage : bil_pkg

/* File: tb/bil_loader_assertions.sv */
// Port checker of the boot image loader, bound into every loader instance.
// Assumes one core_clk domain with rst asynchronous and active high.
module bil_loader_checker #(
  parameter int unsigned SEC_PLL_HZ = 80000000
) (
  input logic                    core_clk,
  input logic                    rst,
  input logic                    boot_start,
  input bil_pkg::bil_svc_req_t   svc_req,
  input bil_pkg::bil_media_cmd_t media_cmd,
  input bil_pkg::bil_mem_wr_t    mem_wr,
  input logic                    boot_done,
  input logic                    boot_ok,
  input logic                    boot_fallback,
  input logic [31:0]             exec_addr,
  input logic                    svc_done,
  input logic                    svc_ok
);
  timeunit 1ns;
  timeprecision 100ps;
  import bil_pkg::*;
  localparam logic [7:0] CLK_DIV = 8'(SEC_PLL_HZ / 20000000);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic started_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) started_ff <= 1'b0;
    else if (media_cmd.en) started_ff <= 1'b1;
  end
  a_start_opens: assert property (boot_start && !started_ff && !boot_done |-> ##[2:3] media_cmd.en)
    else $error("no device open");
  a_fb_route: assert property (boot_fallback && media_cmd.en && !boot_done |-> media_cmd.dev == BIL_DEV_SD
    && media_cmd.chan == 2'h2 && media_cmd.bus_width == 5'h04 && media_cmd.start_unit == 32'h1)
    else $error("bad fallback route");
  a_card_clock: assert property (media_cmd.en && media_cmd.dev inside {BIL_DEV_SD, BIL_DEV_EMMC}
    |-> media_cmd.clk_secondary && media_cmd.clk_div == CLK_DIV) else $error("card clock not 20 MHz");
  a_ecc8_layout: assert property (media_cmd.en && media_cmd.ecc == BIL_ECC8
    |-> media_cmd.ecc_parity == 5'h0d && media_cmd.ecc_ofs == 6'h0c) else $error("ecc8 spare layout wrong");
  a_ecc16_layout: assert property (media_cmd.en && media_cmd.ecc == BIL_ECC16
    |-> media_cmd.ecc_parity == 5'h1a && media_cmd.ecc_ofs == 6'h0c) else $error("ecc16 spare layout wrong");
  a_exec_addr: assert property ($rose(boot_done) |-> exec_addr == (boot_ok ? 32'hd002_0010 : 32'h0))
    else $error("bad entry address");
  a_done_holds: assert property (boot_done |=> boot_done && $stable(boot_ok) && $stable(exec_addr))
    else $error("load result changed");
  a_load_window: assert property (mem_wr.valid && !boot_done
    |-> mem_wr.addr >= 32'hd002_0000 && mem_wr.addr < 32'hd002_4010) else $error("load write outside sram");
  a_svc_pulse: assert property (svc_done |=> !svc_done) else $error("copy done too long");
  a_early_refuse: assert property (svc_req.valid && !started_ff && !boot_start
    |-> ##[1:2] (svc_done && !svc_ok)) else $error("early copy not refused");
  c_boot_ok: cover property ($rose(boot_done) && boot_ok);
  c_fallback: cover property ($rose(boot_fallback));
  c_svc_ok: cover property (svc_done && svc_ok);
endmodule : bil_loader_checker

bind bil_loader bil_loader_checker #(.SEC_PLL_HZ(SEC_PLL_HZ)) i_checker (.*);

/* File: tb/bil_media_model.sv */
// Behavioural boot storage device streaming bytes to the loader while the command is enabled.
// Assumes the bench fills img0 and img2 (channel 2) by hierarchy.
module bil_media_model (
  input  logic                    core_clk,
  input  logic                    rst,
  input  bil_pkg::bil_media_cmd_t media_cmd,
  input  logic                    slow,
  input  logic [15:0]             err_at,
  output bil_pkg::bil_media_rsp_t media_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  import bil_pkg::*;
  logic [7:0]  img0 [64];
  logic [7:0]  img2 [64];
  logic [15:0] idx_ff;
  logic        en_ff;
  logic        tick_ff;
  logic [7:0]  nxt_data;
  always_comb begin
    if (idx_ff >= 16'h0040) nxt_data = idx_ff[7:0];
    else if (media_cmd.chan == 2'h2) nxt_data = img2[idx_ff[5:0]];
    else nxt_data = img0[idx_ff[5:0]];
  end
  // Streams from byte zero of the channel image, whatever unit is requested.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_ff <= 16'h0;
      en_ff <= 1'b0;
      tick_ff <= 1'b0;
      media_rsp <= '0;
    end else begin
      en_ff <= media_cmd.en;
      tick_ff <= ~tick_ff;
      if (media_cmd.en && en_ff && (!slow || tick_ff)) begin
        media_rsp.valid <= 1'b1;
        media_rsp.err <= (idx_ff == err_at);
        media_rsp.data <= nxt_data;
        idx_ff <= idx_ff + 16'h1;
      end else begin
        media_rsp.valid <= 1'b0;
        media_rsp.err <= 1'b0;
        media_rsp.data <= ~media_rsp.data;
        if (!media_cmd.en) idx_ff <= 16'h0;
      end
    end
  end
endmodule : bil_media_model

/* File: tb/tb_top.sv */
// Self-checking bench of the boot image loader with a behavioural storage device.
// Assumes the design package and the default SEC_PLL_HZ, giving a card divider of 4.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import bil_pkg::*;
  logic core_clk, rst, boot_start, slow, en_q, boot_done, boot_ok, boot_fallback, svc_busy, svc_done, svc_ok;
  logic [4:0] boot_bus_width;
  logic [15:0] err_at;
  logic [31:0] exec_addr, last_addr;
  bil_dev_t boot_dev;
  bil_ecc_t boot_ecc;
  bil_nand_geom_t nand_geom;
  bil_media_rsp_t media_rsp;
  bil_svc_req_t svc_req;
  bil_media_cmd_t media_cmd;
  bil_mem_wr_t mem_wr;
  bil_media_cmd_t cmds [4];
  int fails, checks, nwr, ncmd, cyc;

  bil_loader i_dut (.*);
  bil_media_model i_media (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    en_q <= media_cmd.en;
    if (mem_wr.valid === 1'b1) begin
      nwr++;
      last_addr = mem_wr.addr;
    end
    if (media_cmd.en === 1'b1 && en_q !== 1'b1) begin
      cmds[ncmd % 4] = media_cmd;
      ncmd++;
    end
    if (cyc == 60000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic do_reset;
    rst = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    nwr = 0;
    ncmd = 0;
  endtask : do_reset

  // Header: length and byte sum, little endian.
  task automatic load(input bit ch, input int len, input bit bad);
    logic [31:0] s;
    logic [7:0] b [64];
    s = 32'h0;
    for (int i = 0; i < 64; i++) begin
      b[i] = (i >= 16) ? 8'(8'ha0 + i) : 8'h00;
      if (i >= 16 && i < 16 + len) s += 32'(b[i]);
    end
    if (bad) s++;
    for (int k = 0; k < 4; k++) begin
      b[k] = 8'(len >> (8 * k));
      b[8 + k] = s[8 * k +: 8];
    end
    for (int i = 0; i < 64; i++) begin
      if (ch) i_media.img2[i] = b[i];
      else i_media.img0[i] = b[i];
    end
  endtask : load

  task automatic boot(input bil_dev_t d, input bil_ecc_t e);
    boot_dev = d;
    boot_ecc = e;
    boot_start = 1'b1;
    @(posedge core_clk);
    #1 boot_start = 1'b0;
    while (boot_done !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
  endtask : boot

  task automatic t_sd_ok;
    do_reset();
    load(0, 20, 0);
    boot(BIL_DEV_SD, BIL_ECC_NONE);
    chk("start_unit", 32'h1, cmds[0].start_unit);
    chk("clk_sec", 32'h1, cmds[0].clk_secondary);
    chk("clk_div", 32'h4, cmds[0].clk_div);
    chk("writes", 32'h24, nwr);
    chk("last_addr", 32'hd002_0023, last_addr);
    chk("boot_ok", 32'h1, boot_ok);
    chk("exec_addr", 32'hd002_0010, exec_addr);
    chk("fallback", 32'h0, boot_fallback);
  endtask : t_sd_ok

  task automatic t_emmc_fb;
    do_reset();
    slow = 1'b1;
    load(0, 20, 1);
    load(1, 30, 0);
    boot(BIL_DEV_EMMC, BIL_ECC_NONE);
    slow = 1'b0;
    chk("emmc_unit", 32'h0, cmds[0].start_unit);
    chk("fb_dev", 32'(BIL_DEV_SD), cmds[1].dev);
    chk("fb_chan", 32'h2, cmds[1].chan);
    chk("fb_width", 32'h4, cmds[1].bus_width);
    chk("fb_flag", 32'h1, boot_fallback);
    chk("fb_ok", 32'h1, boot_ok);
    chk("fb_writes", 32'h52, nwr);
  endtask : t_emmc_fb

  task automatic t_nand_bad(input bil_ecc_t e, input logic [31:0] par);
    do_reset();
    load(0, 0, 0);
    load(1, 16385, 0);
    boot(BIL_DEV_NAND, e);
    chk("nand_unit", 32'h0, cmds[0].start_unit);
    chk("parity", par, cmds[0].ecc_parity);
    chk("ecc_ofs", 32'hc, cmds[0].ecc_ofs);
    chk("fb_chan", 32'h2, cmds[1].chan);
    chk("bad_ok", 32'h0, boot_ok);
    chk("bad_exec", 32'h0, exec_addr);
  endtask : t_nand_bad

  task automatic svc(input bil_svc_kind_t k, input logic exp_ok, input int exp_n, input logic b16 = 1'b0,
                     input logic [12:0] pb = 13'h0800, input logic [2:0] cy = 3'h5);
    nand_geom = '{page_bytes: pb, bus16: b16, addr_cycles: cy, pages_per_block: 9'h080};
    nwr = 0;
    ncmd = 0;
    svc_req = '{valid: 1'b1, kind: k, block: 32'h1, page: 16'h3, count: 16'h1, dest: 32'h2000_0000,
                bus_width: 5'h08};
    @(posedge core_clk);
    #1 svc_req.valid = 1'b0;
    while (svc_done !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    chk("svc_ok", 32'(exp_ok), svc_ok);
    @(posedge core_clk);
    #1;
    if (exp_n >= 0) chk("svc_bytes", 32'(exp_n), nwr);
    if (exp_n > 0) chk("svc_last", 32'h2000_0000 + 32'(exp_n - 1), last_addr);
  endtask : svc

  task automatic t_svc;
    do_reset();
    svc(BIL_SVC_SD, 1'b0, 0);
    load(0, 20, 0);
    boot(BIL_DEV_SD, BIL_ECC_NONE);
    svc(BIL_SVC_NAND8, 1'b1, 2048);
    svc(BIL_SVC_NAND8, 1'b1, 4096, 1'b0, 13'h1000);
    svc(BIL_SVC_NAND4, 1'b0, 0);
    svc(BIL_SVC_NAND4, 1'b0, 0, 1'b1, 13'h0800, 3'h4);
    svc(BIL_SVC_NAND4, 1'b1, 2048, 1'b1);
    svc(BIL_SVC_NAND8_128P, 1'b1, 2048);
    chk("unit_128p", 32'h83, cmds[0].start_unit);
    svc(BIL_SVC_EMMC, 1'b1, 512);
    chk("emmc_width", 32'h8, cmds[0].bus_width);
    svc(BIL_SVC_SSD_PIO, 1'b1, 512);
    chk("pio", 32'h0, cmds[0].udma);
    svc(BIL_SVC_SSD_UDMA, 1'b1, 512);
    chk("udma", 32'h1, cmds[0].udma);
    svc(BIL_SVC_HYBRID, 1'b1, 2048);
    err_at = 16'h5;
    svc(BIL_SVC_SD, 1'b0, -1);
  endtask : t_svc

  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  initial begin
    fails = 0;
    checks = 0;
    cyc = 0;
    en_q = 1'b0;
    last_addr = 32'h0;
    rst = 1'b1;
    boot_start = 1'b0;
    boot_dev = BIL_DEV_SD;
    boot_ecc = BIL_ECC_NONE;
    boot_bus_width = 5'h04;
    nand_geom = '0;
    svc_req = '0;
    slow = 1'b0;
    err_at = 16'hffff;
    t_sd_ok();
    t_emmc_fb();
    t_nand_bad(BIL_ECC8, 32'hd);
    t_nand_bad(BIL_ECC16, 32'h1a);
    t_svc();
    results();
  end
endmodule : tb_top
